// ==== design/i2ctg_pkg.sv ====
// Purpose: Shared constants for the two-wire target register access block
// Assumes: 100 MHz ref_clk, 64-entry byte register and EEPROM spaces
// Notes: Timing counts, register map places and phase types follow
package i2ctg_pkg;
   localparam int CLK_NS = 10;
   // Fetch and store latency, stretched over on the clock line
   localparam int ACCESS_NS = 200;
   localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
   // Longest time for an address reload
   localparam int LOAD_MAX_NS = 300000;
   localparam int LOAD_CYC = LOAD_MAX_NS / CLK_NS;
   // Both lines high this long frees the bus
   localparam int HIGH_MAX_NS = 50000;
   localparam int IDLE_CYC = HIGH_MAX_NS / CLK_NS;
   localparam int CNT_W = 16;
   localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
   localparam logic [7:0] CMD_RELOAD = 8'h04;
   localparam logic [7:0] EE_READ_MODE = 8'h80;
   localparam logic [7:0] STORED_ADDR_DEFAULT = 8'h8C;
   localparam int ADDR_CTRL_BIT = 7;
   localparam logic [5:0] EE_SA_LOC = 6'h3F;
   localparam logic [5:0] REG_WR_LO = 6'h14;
   localparam logic [5:0] REG_WR_HI = 6'h1D;
   localparam logic [5:0] REG_EE_CTRL = 6'h1F;
   localparam logic [5:0] REG_EE_LO = 6'h20;
   localparam logic [5:0] REG_OWN_ADDR = 6'h3F;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   typedef enum logic [2:0] {
      I2CTG_IDLE, I2CTG_RX, I2CTG_ACK, I2CTG_WAIT, I2CTG_TX, I2CTG_MACK,
      I2CTG_MWAIT
   } i2ctg_phase_t;
   typedef enum logic [1:0] {
      I2CTG_K_ADDR, I2CTG_K_PTR, I2CTG_K_DATA, I2CTG_K_GC
   } i2ctg_kind_t;
endpackage

// ==== design/i2ctg_sync.sv ====
// Purpose: Two-flop synchroniser for pins from outside the clock domain
// Assumes: Inputs are quasi-static levels or slow edges
// Notes: Only the second stage leaves the module
`timescale 1ns/10ps
`default_nettype none
module i2ctg_sync #(
   parameter int W = 4
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [W-1:0] async_in,
   output var logic [W-1:0] sync_out
);
   logic [W-1:0] meta_reg;

   // First stage feeds only the second stage
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_reg <= {W{1'b1}};
         sync_out <= {W{1'b1}};
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// ==== design/i2ctg_target.sv ====
// Purpose: Two-wire bus target with 64-byte register and EEPROM access
// Assumes: Lines and select pins are asynchronous; pull-ups external
// Notes: Address is unloaded after reset until a general-call reload completes
`timescale 1ns/10ps
`default_nettype none
module i2ctg_target #(
   parameter int LOAD_CYCLES = i2ctg_pkg::LOAD_CYC,
   parameter int IDLE_CYCLES = i2ctg_pkg::IDLE_CYC
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe_n,
   input wire logic serial_data_line_in,
   output logic serial_data_line_out,
   output logic serial_data_line_oe_n,
   input wire logic address_select_high_pin,
   input wire logic address_select_low_pin,
   output logic bus_busy,
   output logic address_loaded,
   output logic [6:0] target_address,
   output logic eeprom_read_mode
);
   logic [3:0] sync_w;
   logic scl_s, sda_s, sel_hi_s, sel_lo_s;
   logic scl_d_reg, sda_d_reg;
   logic scl_rise, scl_fall, start_ev, stop_ev;
   i2ctg_pkg::i2ctg_phase_t phase_reg;
   i2ctg_pkg::i2ctg_kind_t kind_reg;
   logic [7:0] shift_reg;
   logic [3:0] bits_reg;
   logic rd_reg;
   logic [5:0] ptr_reg;
   logic [7:0] regs_mem [0:63];
   logic [7:0] eeprom_mem [0:63];
   logic [i2ctg_pkg::CNT_W-1:0] wait_reg;
   logic [i2ctg_pkg::CNT_W-1:0] idle_reg;
   logic [i2ctg_pkg::CNT_W-1:0] load_reg;
   logic reload_pend_reg, loading_reg;
   logic [7:0] rx_byte;
   logic addr_hit, gc_hit, wr_ok;
   logic [7:0] fetch_byte, stored_byte;

   // Short local names for the phase codes; nothing is imported from the
   // package, so the engine and its case labels refer to these
   localparam i2ctg_pkg::i2ctg_phase_t I2CTG_IDLE = i2ctg_pkg::I2CTG_IDLE;
   localparam i2ctg_pkg::i2ctg_phase_t I2CTG_RX = i2ctg_pkg::I2CTG_RX;
   localparam i2ctg_pkg::i2ctg_phase_t I2CTG_ACK = i2ctg_pkg::I2CTG_ACK;
   localparam i2ctg_pkg::i2ctg_phase_t I2CTG_WAIT = i2ctg_pkg::I2CTG_WAIT;
   localparam i2ctg_pkg::i2ctg_phase_t I2CTG_TX = i2ctg_pkg::I2CTG_TX;
   localparam i2ctg_pkg::i2ctg_phase_t I2CTG_MACK = i2ctg_pkg::I2CTG_MACK;
   localparam i2ctg_pkg::i2ctg_phase_t I2CTG_MWAIT = i2ctg_pkg::I2CTG_MWAIT;

   // Line inputs and select pins cross into ref_clk first
   i2ctg_sync #(.W(4)) u_sync (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .async_in({scl_in, serial_data_line_in, address_select_high_pin,
                 address_select_low_pin}),
      .sync_out(sync_w)
   );
   assign scl_s = sync_w[3];
   assign sda_s = sync_w[2];
   assign sel_hi_s = sync_w[1];
   assign sel_lo_s = sync_w[0];

   // Previous synchronised levels for edge and condition detection
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
      end
   end

   // Data edges while the clock stays high are the frame markers
   assign scl_rise = scl_s & ~scl_d_reg;
   assign scl_fall = ~scl_s & scl_d_reg;
   assign start_ev = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   assign stop_ev = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

   // Byte as it stands once the eighth bit is in
   assign rx_byte = shift_reg;
   assign gc_hit = (rx_byte[7:1] == i2ctg_pkg::GEN_CALL_ADDR) & ~rx_byte[0];
   // Own address counts only once it has been loaded
   assign addr_hit = address_loaded
      & (rx_byte[7:1] == target_address);
   assign wr_ok = (ptr_reg >= i2ctg_pkg::REG_WR_LO
      && ptr_reg <= i2ctg_pkg::REG_WR_HI)
      || ptr_reg == i2ctg_pkg::REG_EE_CTRL;
   assign stored_byte = eeprom_mem[i2ctg_pkg::EE_SA_LOC];

   // Read source: EEPROM cells in EEPROM mode, else own address at 3F, EEPROM cells from 20 up, register map below
   always_comb begin
      fetch_byte = regs_mem[ptr_reg];
      if (eeprom_read_mode) begin
         fetch_byte = eeprom_mem[ptr_reg];
      end else if (ptr_reg == i2ctg_pkg::REG_OWN_ADDR) begin
         fetch_byte = {1'b0, target_address};
      end else if (ptr_reg >= i2ctg_pkg::REG_EE_LO) begin
         fetch_byte = eeprom_mem[ptr_reg];
      end
   end

   // Bus busy from start; stop or a long idle high frees it
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bus_busy <= 1'b0;
         idle_reg <= '0;
      end else begin
         if (start_ev) begin
            bus_busy <= 1'b1;
         end else if (stop_ev) begin
            bus_busy <= 1'b0;
         end else if (idle_reg == IDLE_CYCLES[i2ctg_pkg::CNT_W-1:0]) begin
            bus_busy <= 1'b0;
         end
         if (scl_s && sda_s && bus_busy) begin
            idle_reg <= idle_reg + 1'b1;
         end else begin
            idle_reg <= '0;
         end
      end
   end

   // Factory EEPROM image; only the stored address byte is non-zero
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < 64; i++) begin
            eeprom_mem[i] <= 8'h00;
         end
         eeprom_mem[i2ctg_pkg::EE_SA_LOC] <=
            i2ctg_pkg::STORED_ADDR_DEFAULT;
      end
   end

   // Register map; data comes from the end of the write stretch
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < 64; i++) begin
            regs_mem[i] <= 8'h00;
         end
      end else if (phase_reg == I2CTG_WAIT && wait_reg == '0 && !rd_reg
                   && kind_reg == i2ctg_pkg::I2CTG_K_DATA && wr_ok) begin
         regs_mem[ptr_reg] <= shift_reg;
      end
   end

   // EEPROM mode follows the control register; master sets and clears it
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         eeprom_read_mode <= 1'b0;
      end else begin
         eeprom_read_mode <= regs_mem[i2ctg_pkg::REG_EE_CTRL] ==
            i2ctg_pkg::EE_READ_MODE;
      end
   end

   // Reload arms on command byte, runs after the stop, bounded in time
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reload_pend_reg <= 1'b0;
         loading_reg <= 1'b0;
         load_reg <= '0;
         address_loaded <= 1'b0;
         target_address <= '0;
      end else begin
         if (phase_reg == I2CTG_RX && kind_reg == i2ctg_pkg::I2CTG_K_GC
             && scl_fall && bits_reg == i2ctg_pkg::BYTE_BITS) begin
            // Other commands are acknowledged and have no effect
            reload_pend_reg <= rx_byte == i2ctg_pkg::CMD_RELOAD;
         end else if (start_ev) begin
            reload_pend_reg <= 1'b0;
         end
         if (stop_ev && reload_pend_reg) begin
            reload_pend_reg <= 1'b0;
            loading_reg <= 1'b1;
            load_reg <= '0;
         end else if (loading_reg) begin
            load_reg <= load_reg + 1'b1;
            if (load_reg == LOAD_CYCLES[i2ctg_pkg::CNT_W-1:0] - 1'b1) begin
               loading_reg <= 1'b0;
               address_loaded <= 1'b1;
               if (stored_byte[i2ctg_pkg::ADDR_CTRL_BIT]) begin
                  target_address <= {stored_byte[6:2], sel_hi_s,
                                     sel_lo_s};
               end else begin
                  target_address <= stored_byte[6:0];
               end
            end
         end
      end
   end

   // Byte-level protocol engine
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         phase_reg <= I2CTG_IDLE;
         kind_reg <= i2ctg_pkg::I2CTG_K_ADDR;
         shift_reg <= 8'h00;
         bits_reg <= 4'h0;
         rd_reg <= 1'b0;
         ptr_reg <= 6'h00;
         wait_reg <= '0;
         serial_data_line_oe_n <= 1'b1;
         scl_oe_n <= 1'b1;
      end else if (start_ev) begin
         // A repeated start drops whatever was in flight
         phase_reg <= I2CTG_RX;
         kind_reg <= i2ctg_pkg::I2CTG_K_ADDR;
         rd_reg <= 1'b0;
         bits_reg <= 4'h0;
         serial_data_line_oe_n <= 1'b1;
         scl_oe_n <= 1'b1;
      end else if (stop_ev) begin
         phase_reg <= I2CTG_IDLE;
         serial_data_line_oe_n <= 1'b1;
         scl_oe_n <= 1'b1;
      end else if (!bus_busy) begin
         phase_reg <= I2CTG_IDLE;
         serial_data_line_oe_n <= 1'b1;
         scl_oe_n <= 1'b1;
      end else begin
         case (phase_reg)
            I2CTG_RX: begin
               if (scl_rise) begin
                  shift_reg <= {shift_reg[6:0], sda_s};
                  bits_reg <= bits_reg + 1'b1;
               end else if (scl_fall && bits_reg == i2ctg_pkg::BYTE_BITS) begin
                  case (kind_reg)
                     i2ctg_pkg::I2CTG_K_ADDR: begin
                        if (addr_hit && rx_byte[0]) begin
                           rd_reg <= 1'b1;
                           serial_data_line_oe_n <= 1'b0;
                           phase_reg <= I2CTG_ACK;
                        end else if (addr_hit || gc_hit) begin
                           rd_reg <= 1'b0;
                           kind_reg <= gc_hit ? i2ctg_pkg::I2CTG_K_GC
                                              : i2ctg_pkg::I2CTG_K_PTR;
                           serial_data_line_oe_n <= 1'b0;
                           phase_reg <= I2CTG_ACK;
                        end else begin
                           phase_reg <= I2CTG_IDLE;
                        end
                     end
                     i2ctg_pkg::I2CTG_K_PTR: begin
                        ptr_reg <= rx_byte[5:0];
                        kind_reg <= i2ctg_pkg::I2CTG_K_DATA;
                        serial_data_line_oe_n <= 1'b0;
                        phase_reg <= I2CTG_ACK;
                     end
                     i2ctg_pkg::I2CTG_K_DATA: begin
                        // Hold the clock low while the byte is stored
                        scl_oe_n <= 1'b0;
                        wait_reg <= i2ctg_pkg::CNT_W'(i2ctg_pkg::ACCESS_CYC);
                        phase_reg <= I2CTG_WAIT;
                     end
                     default: begin
                        serial_data_line_oe_n <= 1'b0;
                        phase_reg <= I2CTG_ACK;
                     end
                  endcase
               end
            end
            I2CTG_ACK: begin
               if (scl_fall) begin
                  serial_data_line_oe_n <= 1'b1;
                  bits_reg <= 4'h0;
                  if (rd_reg) begin
                     // Stretch while the first read byte is fetched
                     scl_oe_n <= 1'b0;
                     wait_reg <= i2ctg_pkg::CNT_W'(i2ctg_pkg::ACCESS_CYC);
                     phase_reg <= I2CTG_WAIT;
                  end else begin
                     phase_reg <= I2CTG_RX;
                  end
               end
            end
            I2CTG_WAIT: begin
               if (wait_reg != '0) begin
                  wait_reg <= wait_reg - 1'b1;
               end else begin
                  scl_oe_n <= 1'b1;
                  ptr_reg <= ptr_reg + 1'b1;
                  if (rd_reg) begin
                     shift_reg <= fetch_byte;
                     serial_data_line_oe_n <= fetch_byte[7];
                     bits_reg <= 4'h0;
                     phase_reg <= I2CTG_TX;
                  end else begin
                     serial_data_line_oe_n <= 1'b0;
                     phase_reg <= I2CTG_ACK;
                  end
               end
            end
            I2CTG_TX: begin
               if (scl_fall) begin
                  if (bits_reg[2:0] == i2ctg_pkg::LAST_BIT) begin
                     serial_data_line_oe_n <= 1'b1;
                     phase_reg <= I2CTG_MACK;
                  end else begin
                     // A one is sent by releasing the line
                     serial_data_line_oe_n <= shift_reg[6];
                     shift_reg <= {shift_reg[6:0], 1'b0};
                     bits_reg <= bits_reg + 1'b1;
                  end
               end
            end
            I2CTG_MACK: begin
               if (scl_rise) begin
                  phase_reg <= sda_s ? I2CTG_IDLE : I2CTG_MWAIT;
               end
            end
            I2CTG_MWAIT: begin
               if (scl_fall) begin
                  scl_oe_n <= 1'b0;
                  wait_reg <= i2ctg_pkg::CNT_W'(i2ctg_pkg::ACCESS_CYC);
                  phase_reg <= I2CTG_WAIT;
               end
            end
            default: begin
               serial_data_line_oe_n <= 1'b1;
               scl_oe_n <= 1'b1;
            end
         endcase
      end
   end

   // Driven level is always low; lines are only pulled or released
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         scl_out <= 1'b0;
         serial_data_line_out <= 1'b0;
      end else begin
         scl_out <= 1'b0;
         serial_data_line_out <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ==== verif/i2ctg_target_sva.sv ====
// Purpose: Port-level checks of the two-wire target
// Assumes: Stored control flag set, select pins static during a load
// Notes: Bound to every i2ctg_target instance
`timescale 1ns/10ps
`default_nettype none
module i2ctg_target_sva #(
   parameter int LOAD_CYCLES = 20,
   parameter int IDLE_CYCLES = 200
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic scl_in,
   input wire logic scl_out,
   input wire logic scl_oe_n,
   input wire logic serial_data_line_in,
   input wire logic serial_data_line_out,
   input wire logic serial_data_line_oe_n,
   input wire logic address_select_high_pin,
   input wire logic address_select_low_pin,
   input wire logic bus_busy,
   input wire logic address_loaded,
   input wire logic [6:0] target_address,
   input wire logic eeprom_read_mode
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   logic [15:0] hi_cnt;
   logic [15:0] free_cnt;
   // Spell of both lines high, and of an idle bus; both saturate
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         hi_cnt <= 16'h0000;
      end else if (!(scl_in && serial_data_line_in)) begin
         hi_cnt <= 16'h0000;
      end else if (hi_cnt != 16'hFFFF) begin
         hi_cnt <= hi_cnt + 16'h0001;
      end
   end
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         free_cnt <= 16'h0000;
      end else if (bus_busy) begin
         free_cnt <= 16'h0000;
      end else if (free_cnt != 16'hFFFF) begin
         free_cnt <= free_cnt + 16'h0001;
      end
   end
   // Line changes before the edge are excluded: a read bit lands with release
   property p_od;
      scl_out == 1'b0 && serial_data_line_out == 1'b0;
   endproperty
   a_od: assert property (p_od) else $error("line driven high");
   property p_str_low;
      $fell(scl_oe_n) |-> !$past(scl_in);
   endproperty
   a_str_low: assert property (p_str_low) else $error("stretch early");
   property p_str_len;
      $fell(scl_oe_n) |-> !scl_oe_n [*8] ##[8:16] scl_oe_n;
   endproperty
   a_str_len: assert property (p_str_len) else $error("stretch span");
   property p_busy_on;
      $fell(serial_data_line_in) && scl_in && $past(scl_in) |->
         ##[1:8] bus_busy;
   endproperty
   a_busy_on: assert property (p_busy_on) else $error("start missed");
   property p_busy_off;
      $rose(serial_data_line_in) && scl_in && $past(scl_in) |->
         ##[1:8] !bus_busy;
   endproperty
   a_busy_off: assert property (p_busy_off) else $error("stop missed");
   property p_idle;
      hi_cnt == 16'(IDLE_CYCLES + 8) |-> !bus_busy;
   endproperty
   a_idle: assert property (p_idle) else $error("idle timeout missed");
   property p_sda_chg;
      $changed(serial_data_line_oe_n) |-> !$past(scl_in);
   endproperty
   a_sda_chg: assert property (p_sda_chg) else $error("data moved high");
   property p_unl;
      !address_loaded |-> target_address == 7'h00;
   endproperty
   a_unl: assert property (p_unl) else $error("address before load");
   property p_merge;
      $rose(address_loaded) |-> target_address[1:0] ==
         {address_select_high_pin, address_select_low_pin};
   endproperty
   a_merge: assert property (p_merge) else $error("pins not merged");
   property p_load_t;
      $rose(address_loaded) |-> free_cnt >= 16'(LOAD_CYCLES - 4) &&
         free_cnt <= 16'(LOAD_CYCLES + 6);
   endproperty
   a_load_t: assert property (p_load_t) else $error("load timing");
   c_str: cover property ($fell(scl_oe_n));
   c_load: cover property ($rose(address_loaded));
   c_ee: cover property ($rose(eeprom_read_mode));
endmodule
bind i2ctg_target i2ctg_target_sva #(.LOAD_CYCLES(LOAD_CYCLES),
   .IDLE_CYCLES(IDLE_CYCLES)) u_sva (.ref_clk(ref_clk), .sys_rst(sys_rst),
   .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
   .serial_data_line_in(serial_data_line_in),
   .serial_data_line_out(serial_data_line_out),
   .serial_data_line_oe_n(serial_data_line_oe_n),
   .address_select_high_pin(address_select_high_pin),
   .address_select_low_pin(address_select_low_pin),
   .bus_busy(bus_busy), .address_loaded(address_loaded),
   .target_address(target_address), .eeprom_read_mode(eeprom_read_mode));
`default_nettype wire

// ==== verif/i2ctg_master_model.sv ====
// Purpose: Bus master model, 160 ns clock period, open-drain lines
// Assumes: Pull-ups on both lines; rel high means released
// Notes: Waits out stretching for at most 100 cycles
`timescale 1ns/10ps
`default_nettype none
module i2ctg_master_model (
   input wire logic ref_clk,
   input wire logic scl_line,
   input wire logic sda_line,
   output logic scl_rel,
   output logic sda_rel,
   output logic stall_err
);
   // Lines released and clock still outside frames
   initial begin
      scl_rel = 1'b1;
      sda_rel = 1'b1;
      stall_err = 1'b0;
   end
   task automatic hc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // Release the clock, then wait while the target holds it low
   task automatic rise();
      int k;
      scl_rel <= 1'b1;
      k = 0;
      @(posedge ref_clk);
      while (!scl_line && k < 100) begin
         @(posedge ref_clk);
         k++;
      end
      if (k >= 100) stall_err <= 1'b1;
   endtask
   // Start or repeated start; only the master makes these
   task automatic start();
      sda_rel <= 1'b1;
      hc(4);
      rise();
      hc(8);
      sda_rel <= 1'b0;
      hc(8);
      scl_rel <= 1'b0;
      hc(4);
   endtask
   task automatic stop();
      sda_rel <= 1'b0;
      hc(4);
      rise();
      hc(8);
      sda_rel <= 1'b1;
      hc(8);
   endtask
   // Data set in the low phase, sampled late in the high phase
   task automatic bit_x(input logic b, output logic r);
      sda_rel <= b;
      hc(4);
      rise();
      hc(7);
      r = sda_line;
      scl_rel <= 1'b0;
      hc(4);
   endtask
   task automatic send(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], r);
      end
      bit_x(1'b1, r);
      ack = !r;
   endtask
   task automatic recv(input logic mack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, r);
         d[i] = r;
      end
      bit_x(!mack, r);
   endtask
   // Both lines high with no stop, for the idle timeout
   task automatic idle_rel();
      sda_rel <= 1'b1;
      hc(4);
      scl_rel <= 1'b1;
   endtask
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// Purpose: Self-checking bench for the two-wire target
// Assumes: Short load and idle counts; fixed seed 12
// Notes: Expected reads come from a bench-side register image
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam int LOADC = 20;
   localparam int IDLEC = 200;
   logic ref_clk, sys_rst, sel_hi, sel_lo, m_scl, m_sda, stall_err;
   logic scl_oe_n, sda_oe_n, bus_busy, address_loaded, eeprom_read_mode;
   logic scl_w, sda_w, a;
   logic [6:0] target_address, tgt_exp;
   logic [7:0] mem [64];
   logic [7:0] wq [16];
   int err_total, compares, k;
   // Open-drain wires with pull-ups
   assign scl_w = scl_oe_n & m_scl;
   assign sda_w = sda_oe_n & m_sda;
   i2ctg_target #(.LOAD_CYCLES(LOADC), .IDLE_CYCLES(IDLEC)) dut (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .scl_in(scl_w), .scl_out(),
      .scl_oe_n(scl_oe_n), .serial_data_line_in(sda_w),
      .serial_data_line_out(), .serial_data_line_oe_n(sda_oe_n),
      .address_select_high_pin(sel_hi), .address_select_low_pin(sel_lo),
      .bus_busy(bus_busy), .address_loaded(address_loaded),
      .target_address(target_address), .eeprom_read_mode(eeprom_read_mode));
   i2ctg_master_model u_m (.ref_clk(ref_clk), .scl_line(scl_w),
      .sda_line(sda_w), .scl_rel(m_scl), .sda_rel(m_sda),
      .stall_err(stall_err));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic chk(input string nm, input logic [7:0] e,
      input logic [7:0] g);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic end_sim();
      if (err_total == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Read map: EEPROM mode, own address, EEPROM window, registers
   function automatic logic [7:0] exp_rd(input logic [5:0] p);
      if (mem[31] == 8'h80) return (p == 6'h3F) ? 8'h8C : 8'h00;
      if (p == 6'h3F) return {1'b0, tgt_exp};
      if (p >= 6'h20) return 8'h00;
      return mem[p];
   endfunction
   // Pointer then n data bytes; no stop, so a caller may restart
   task automatic wr(input logic [5:0] p, input int n);
      logic ak;
      u_m.start();
      u_m.send({tgt_exp, 1'b0}, ak);
      chk("wr_addr_ack", 8'h01, {7'h00, ak});
      u_m.send({2'h0, p}, ak);
      for (int i = 0; i < n; i++) begin
         u_m.send(wq[i], ak);
         chk("wr_data_ack", 8'h01, {7'h00, ak});
         if ((p >= 6'h14 && p <= 6'h1D) || p == 6'h1F) mem[p] = wq[i];
         p++;
      end
   endtask
   task automatic rd(input logic [5:0] p, input int n);
      logic ak;
      logic [7:0] v;
      wr(p, 0);
      u_m.start();
      u_m.send({tgt_exp, 1'b1}, ak);
      chk("rd_addr_ack", 8'h01, {7'h00, ak});
      for (int i = 0; i < n; i++) begin
         u_m.recv(i < n - 1, v);
         chk("rd_data", exp_rd(p), v);
         p++;
      end
      u_m.stop();
   endtask
   task automatic rnd_q();
      foreach (wq[i]) wq[i] = 8'($urandom_range(255, 0));
   endtask
   // Watchdog: the tests take about 12000 cycles
   initial begin
      repeat (80000) @(posedge ref_clk);
      err_total++;
      end_sim();
   end
   initial begin
      sys_rst = 1'b1;
      sel_hi = 1'b0;
      sel_lo = 1'b0;
      err_total = 0;
      compares = 0;
      tgt_exp = 7'h00;
      foreach (mem[i]) mem[i] = 8'h00;
      void'($urandom(12));
      // Second edge: the first may race the reset edge at time zero
      repeat (2) @(posedge ref_clk);
      chk("rst_lines", 8'h03, {5'h00, bus_busy, scl_oe_n, sda_oe_n});
      chk("rst_addr", 8'h00, {address_loaded, target_address});
      repeat (18) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      // Before load only the general call is answered
      u_m.start();
      u_m.send({7'h0C, 1'b0}, a);
      chk("unl_nack", 8'h00, {7'h00, a});
      u_m.stop();
      u_m.start();
      u_m.send(8'h00, a);
      chk("gc_ack", 8'h01, {7'h00, a});
      u_m.send(8'($urandom_range(255, 5)), a);
      u_m.stop();
      repeat (LOADC + 40) @(posedge ref_clk);
      chk("gc_other", 8'h00, {7'h00, address_loaded});
      sel_hi <= 1'($urandom_range(1, 0));
      sel_lo <= 1'($urandom_range(1, 0));
      u_m.start();
      u_m.send(8'h00, a);
      u_m.send(8'h04, a);
      chk("reload_ack", 8'h01, {7'h00, a});
      u_m.stop();
      k = 0;
      while (address_loaded !== 1'b1 && k < LOADC + 20) begin
         @(posedge ref_clk);
         k++;
      end
      tgt_exp = {5'h03, sel_hi, sel_lo};
      chk("loaded_addr", {1'b0, tgt_exp}, {1'b0, target_address});
      u_m.start();
      u_m.send({tgt_exp ^ 7'h40, 1'b0}, a);
      chk("other_nack", 8'h00, {7'h00, a});
      u_m.stop();
      // Random burst over the writable block, read back
      rnd_q();
      wr(6'h14, 10);
      u_m.stop();
      rd(6'h14, 10);
      // Read-only places across the wrap
      rnd_q();
      wr(6'h3E, 3);
      u_m.stop();
      rd(6'h3E, 4);
      // Write cut short by a repeated start
      rnd_q();
      wr(6'h16, 2);
      rd(6'h16, 3);
      wq[0] = 8'h80;
      wr(6'h1F, 1);
      u_m.stop();
      chk("ee_on", 8'h01, {7'h00, eeprom_read_mode});
      rd(6'h3F, 2);
      wq[0] = 8'h00;
      wr(6'h1F, 1);
      u_m.stop();
      chk("ee_off", 8'h00, {7'h00, eeprom_read_mode});
      // Idle after both lines high without a stop
      u_m.start();
      chk("busy_on", 8'h01, {7'h00, bus_busy});
      u_m.idle_rel();
      repeat (IDLEC + 20) @(posedge ref_clk);
      chk("busy_idle", 8'h00, {7'h00, bus_busy});
      rd(6'h14, 1);
      chk("stall", 8'h00, {7'h00, stall_err});
      end_sim();
   end
endmodule
`default_nettype wire
